/* File: design/cascade_timer_top.sv */
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Channels run alone or as cascaded pair
// - Alone: interval, event, square wave, PWM
// - Cascade: interval, event, square; no PWM
// - Read-only 8-bit count, increments per tick
// - Cascaded count read as one 16-bit word
// - Count clears on reset, stop, clear-mode match
// - Lower run bit clears whole cascade
// - Compare register 8-bit, any value writable
// - Outside PWM, equality raises match interrupt
// - PWM: overflow activates, match deactivates output
// - Cascade: 16-bit compare, lower channel interrupt
// - Run 0 clears and halts, 1 counts
// - Mode bit: 0 clear-restart, 1 PWM
// - Cascade bit on upper only, lower fixed 0
// - Stopping PWM forces output inactive
module cascade_timer_top
  import timer_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] event_input_pin,
  input wire logic [1:0] aux_count_tick,
  output logic [1:0] timer_output_pin,
  output logic [1:0] compare_match_irq
);

  // ***************************************************************
  // Bus state
  // ***************************************************************
  logic aw_free_r, aw_free_nxt;
  logic w_free_r, w_free_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic do_write;

  // ***************************************************************
  // Register state
  // ***************************************************************
  logic [7:0] mode_control_register_r [2];
  logic [7:0] mode_nxt [2];
  logic [2:0] count_clock_select_register_r [2];
  logic [2:0] clksel_nxt [2];
  logic [7:0] channel_compare_value_r [2];
  logic [7:0] cmp_nxt [2];
  logic [1:0] ff_set_r, ff_set_nxt;
  logic [1:0] ff_clr_r, ff_clr_nxt;
  logic [PRESCALE_W-1:0] prescale_r, prescale_nxt;
  logic [1:0] ev_prev_r, ev_prev_nxt;

  logic cascade_select_bit;
  logic [7:0] lower_stage_counter;
  logic [7:0] upper_stage_counter;
  logic [15:0] cascaded_count_value;
  logic [15:0] cascaded_compare_value;
  logic [1:0] sel_tick;
  logic [1:0] eq;
  logic [1:0] match;
  logic [1:0] carry;
  logic [1:0] chan_tick;
  logic [1:0] chan_clr;
  chan_ctrl_t ctrl [2];
  logic [7:0] stage_count [2];

  assign cascade_select_bit = mode_control_register_r[1][BIT_CASC];
  assign cascaded_count_value = {upper_stage_counter, lower_stage_counter};
  assign cascaded_compare_value = {channel_compare_value_r[1], channel_compare_value_r[0]};

  assign s_axi_awready = aw_free_r;
  assign s_axi_wready = w_free_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ***************************************************************
  // Count clock selection
  // ***************************************************************
  always_comb begin
    prescale_nxt = prescale_r + 1'b1;
    ev_prev_nxt = event_input_pin;
    for (int i = 0; i < 2; i++) begin
      case (count_clock_select_register_r[i])
        CLK_EV_FALL: sel_tick[i] = ev_prev_r[i] & !event_input_pin[i];
        CLK_EV_RISE: sel_tick[i] = !ev_prev_r[i] & event_input_pin[i];
        CLK_DIV1: sel_tick[i] = 1'b1;
        CLK_DIV2: sel_tick[i] = &prescale_r[0:0];
        CLK_DIV4: sel_tick[i] = &prescale_r[1:0];
        CLK_DIV64: sel_tick[i] = &prescale_r[5:0];
        CLK_DIV256: sel_tick[i] = &prescale_r[7:0];
        CLK_AUX: sel_tick[i] = aux_count_tick[i];
        default: sel_tick[i] = 1'b0;
      endcase
    end
  end

  // ***************************************************************
  // Channel steering
  // ***************************************************************
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ctrl[i].run = mode_control_register_r[i][BIT_RUN];
      ctrl[i].pwm = mode_control_register_r[i][BIT_PWM];
      ctrl[i].inv_en = mode_control_register_r[i][BIT_INV];
      ctrl[i].low_active = mode_control_register_r[i][BIT_INV];
      ctrl[i].out_en = mode_control_register_r[i][BIT_OUT_EN];
    end
    eq[0] = lower_stage_counter == channel_compare_value_r[0];
    eq[1] = upper_stage_counter == channel_compare_value_r[1];
    if (cascade_select_bit) begin
      ctrl[0].pwm = 1'b0;
      ctrl[1].pwm = 1'b0;
      ctrl[1].run = ctrl[0].run;
      eq[0] = cascaded_count_value == cascaded_compare_value;
      eq[1] = 1'b0;
    end
  end

  // Kept apart from the steering so the carry path does not loop back into it
  always_comb begin
    chan_tick = sel_tick;
    chan_clr = 2'b00;
    if (cascade_select_bit) begin
      chan_tick[1] = carry[0];
      chan_clr[1] = match[0];
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_chan
    timer_channel #(
      .WIDTH(8)
    ) u_chan (
      .aclk(aclk),
      .aresetn(aresetn),
      .ctrl(ctrl[g]),
      .tick(chan_tick[g]),
      .eq(eq[g]),
      .clr(chan_clr[g]),
      .ff_set(ff_set_r[g]),
      .ff_clr(ff_clr_r[g]),
      .count_r(stage_count[g]),
      .match(match[g]),
      .carry(carry[g]),
      .irq_r(compare_match_irq[g]),
      .pin_r(timer_output_pin[g])
    );
  end
  assign lower_stage_counter = stage_count[0];
  assign upper_stage_counter = stage_count[1];

  // ***************************************************************
  // AXI write path
  // ***************************************************************
  assign do_write = !aw_free_r & !w_free_r & !bvalid_r;

  always_comb begin
    aw_free_nxt = aw_free_r ? !s_axi_awvalid : do_write;
    w_free_nxt = w_free_r ? !s_axi_wvalid : do_write;
    awaddr_nxt = (aw_free_r && s_axi_awvalid) ? s_axi_awaddr : awaddr_r;
    wdata_nxt = (w_free_r && s_axi_wvalid) ? s_axi_wdata : wdata_r;
    wstrb_nxt = (w_free_r && s_axi_wvalid) ? s_axi_wstrb : wstrb_r;
    bvalid_nxt = bvalid_r ? !s_axi_bready : do_write;
    bresp_nxt = bresp_r;
    mode_nxt = mode_control_register_r;
    clksel_nxt = count_clock_select_register_r;
    cmp_nxt = channel_compare_value_r;
    ff_set_nxt = 2'b00;
    ff_clr_nxt = 2'b00;
    if (do_write) begin
      bresp_nxt = RESP_OKAY;
      case (awaddr_r)
        OFS_MODE_LO, OFS_MODE_HI: begin
          if (wstrb_r[0]) begin
            // Lower stage keeps its cascade bit at zero
            mode_nxt[awaddr_r[2]] = wdata_r[7:0] & (awaddr_r[2] ? MODE_MASK_HI : MODE_MASK_LO);
            ff_set_nxt[awaddr_r[2]] = wdata_r[BIT_FF_SET] & !wdata_r[BIT_FF_CLR];
            ff_clr_nxt[awaddr_r[2]] = wdata_r[BIT_FF_CLR] & !wdata_r[BIT_FF_SET];
          end
        end
        OFS_CLKSEL_LO, OFS_CLKSEL_HI: begin
          if (wstrb_r[0]) begin
            clksel_nxt[awaddr_r[2]] = wdata_r[2:0];
          end
        end
        OFS_CMP_LO, OFS_CMP_HI: begin
          if (wstrb_r[0]) begin
            cmp_nxt[awaddr_r[2]] = wdata_r[7:0];
          end
        end
        OFS_CASC_CMP: begin
          if (wstrb_r[0]) begin
            cmp_nxt[0] = wdata_r[7:0];
          end
          if (wstrb_r[1]) begin
            cmp_nxt[1] = wdata_r[15:8];
          end
        end
        OFS_CNT_LO, OFS_CNT_HI, OFS_CASC_CNT: bresp_nxt = RESP_OKAY;
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
  end

  // ***************************************************************
  // AXI read path
  // ***************************************************************
  always_comb begin
    arready_nxt = arready_r ? !s_axi_arvalid : (rvalid_r & s_axi_rready);
    rvalid_nxt = rvalid_r ? !s_axi_rready : s_axi_arvalid;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (arready_r && s_axi_arvalid) begin
      rdata_nxt = 32'h00000000;
      rresp_nxt = RESP_OKAY;
      case (s_axi_araddr)
        OFS_MODE_LO: rdata_nxt[7:0] = mode_control_register_r[0];
        OFS_MODE_HI: rdata_nxt[7:0] = mode_control_register_r[1];
        OFS_CLKSEL_LO: rdata_nxt[2:0] = count_clock_select_register_r[0];
        OFS_CLKSEL_HI: rdata_nxt[2:0] = count_clock_select_register_r[1];
        OFS_CMP_LO: rdata_nxt[7:0] = channel_compare_value_r[0];
        OFS_CMP_HI: rdata_nxt[7:0] = channel_compare_value_r[1];
        OFS_CNT_LO, OFS_CNT_HI: begin
          // Halves are refused while cascaded so a torn read cannot pass
          if (cascade_select_bit) begin
            rresp_nxt = RESP_SLVERR;
          end else begin
            rdata_nxt[7:0] = s_axi_araddr[2] ? upper_stage_counter : lower_stage_counter;
          end
        end
        OFS_CASC_CNT: rdata_nxt[15:0] = cascaded_count_value;
        OFS_CASC_CMP: rdata_nxt[15:0] = cascaded_compare_value;
        default: rresp_nxt = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_free_r <= 1'b1;
      w_free_r <= 1'b1;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
      for (int i = 0; i < 2; i++) begin
        mode_control_register_r[i] <= MODE_RESET;
        count_clock_select_register_r[i] <= CLKSEL_RESET;
        channel_compare_value_r[i] <= CMP_RESET;
      end
      ff_set_r <= 2'b00;
      ff_clr_r <= 2'b00;
      prescale_r <= '0;
      ev_prev_r <= 2'b00;
    end else begin
      aw_free_r <= aw_free_nxt;
      w_free_r <= w_free_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      mode_control_register_r <= mode_nxt;
      count_clock_select_register_r <= clksel_nxt;
      channel_compare_value_r <= cmp_nxt;
      ff_set_r <= ff_set_nxt;
      ff_clr_r <= ff_clr_nxt;
      prescale_r <= prescale_nxt;
      ev_prev_r <= ev_prev_nxt;
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  property p_casc_stop;
    @(posedge aclk) disable iff (!aresetn)
      (cascade_select_bit && !mode_control_register_r[0][BIT_RUN]) |=> cascaded_count_value == 16'h0000;
  endproperty
  a_casc_stop: assert property (p_casc_stop) else $error("cascade not cleared by lower run bit");

  property p_lower_casc_bit;
    @(posedge aclk) disable iff (!aresetn) !mode_control_register_r[0][BIT_CASC];
  endproperty
  a_lower_casc_bit: assert property (p_lower_casc_bit) else $error("lower cascade bit set");

  property p_casc_match;
    @(posedge aclk) disable iff (!aresetn)
      (cascade_select_bit && mode_control_register_r[0][BIT_RUN] && chan_tick[0] &&
       cascaded_count_value == cascaded_compare_value) |=> compare_match_irq[0] && !compare_match_irq[1];
  endproperty
  a_casc_match: assert property (p_casc_match) else $error("cascade match missed lower irq");

  property p_casc_no_pwm;
    @(posedge aclk) disable iff (!aresetn) cascade_select_bit |-> !ctrl[0].pwm && !ctrl[1].pwm;
  endproperty
  a_casc_no_pwm: assert property (p_casc_no_pwm) else $error("pwm active in cascade");

  property p_half_refused;
    @(posedge aclk) disable iff (!aresetn)
      (arready_r && s_axi_arvalid && cascade_select_bit &&
       (s_axi_araddr == OFS_CNT_LO || s_axi_araddr == OFS_CNT_HI)) |=> rvalid_r && rresp_r == RESP_SLVERR;
  endproperty
  a_half_refused: assert property (p_half_refused) else $error("count half read while cascaded");

  property p_cmp_write;
    @(posedge aclk) disable iff (!aresetn)
      (do_write && awaddr_r == OFS_CMP_LO && wstrb_r[0]) |=> channel_compare_value_r[0] == $past(wdata_r[7:0]);
  endproperty
  a_cmp_write: assert property (p_cmp_write) else $error("compare write did not land");

endmodule
`default_nettype wire

/* File: common/timer_pkg.sv */
package timer_pkg;

  // ***************************************************************
  // Register map (byte addresses)
  // ***************************************************************
  localparam logic [7:0] OFS_MODE_LO = 8'h00;
  localparam logic [7:0] OFS_MODE_HI = 8'h04;
  localparam logic [7:0] OFS_CLKSEL_LO = 8'h08;
  localparam logic [7:0] OFS_CLKSEL_HI = 8'h0C;
  localparam logic [7:0] OFS_CMP_LO = 8'h10;
  localparam logic [7:0] OFS_CMP_HI = 8'h14;
  localparam logic [7:0] OFS_CNT_LO = 8'h18;
  localparam logic [7:0] OFS_CNT_HI = 8'h1C;
  localparam logic [7:0] OFS_CASC_CNT = 8'h20;
  localparam logic [7:0] OFS_CASC_CMP = 8'h24;

  // ***************************************************************
  // Mode control register fields
  // ***************************************************************
  localparam int BIT_RUN = 7;
  localparam int BIT_PWM = 6;
  localparam int BIT_CASC = 4;
  localparam int BIT_FF_SET = 3;
  localparam int BIT_FF_CLR = 2;
  localparam int BIT_INV = 1;
  localparam int BIT_OUT_EN = 0;
  localparam logic [7:0] MODE_MASK_LO = 8'hC3;
  localparam logic [7:0] MODE_MASK_HI = 8'hD3;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [2:0] CLKSEL_RESET = 3'h0;
  localparam logic [7:0] CMP_RESET = 8'h00;

  // ***************************************************************
  // Count clock selection codes
  // ***************************************************************
  localparam logic [2:0] CLK_EV_FALL = 3'h0;
  localparam logic [2:0] CLK_EV_RISE = 3'h1;
  localparam logic [2:0] CLK_DIV1 = 3'h2;
  localparam logic [2:0] CLK_DIV2 = 3'h3;
  localparam logic [2:0] CLK_DIV4 = 3'h4;
  localparam logic [2:0] CLK_DIV64 = 3'h5;
  localparam logic [2:0] CLK_DIV256 = 3'h6;
  localparam logic [2:0] CLK_AUX = 3'h7;
  localparam int PRESCALE_W = 8;

  // ***************************************************************
  // AXI responses
  // ***************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic run;
    logic pwm;
    logic inv_en;
    logic low_active;
    logic out_en;
  } chan_ctrl_t;

endpackage

/* File: design/timer_channel.sv */
`timescale 1ns/1ps
`default_nettype none
module timer_channel
  import timer_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire chan_ctrl_t ctrl,
  input wire logic tick,
  input wire logic eq,
  input wire logic clr,
  input wire logic ff_set,
  input wire logic ff_clr,
  output logic [WIDTH-1:0] count_r,
  output logic match,
  output logic carry,
  output logic irq_r,
  output logic pin_r
);

  if (WIDTH < 2) begin : g_bad_width
    $error("timer_channel: WIDTH must be at least 2");
  end

  logic [WIDTH-1:0] count_nxt;
  logic ff_r;
  logic ff_nxt;
  logic irq_nxt;
  logic pin_nxt;
  logic at_max;
  logic ovf;
  logic pwm_match;

  // ***************************************************************
  // Counter
  // ***************************************************************
  assign at_max = (count_r == {WIDTH{1'b1}});
  assign match = ctrl.run & tick & eq & !ctrl.pwm;
  assign pwm_match = ctrl.run & tick & eq & ctrl.pwm;
  assign ovf = ctrl.run & tick & ctrl.pwm & at_max;
  assign carry = ctrl.run & tick & at_max & !match;

  always_comb begin
    count_nxt = count_r;
    if (!ctrl.run || clr) begin
      count_nxt = '0;
    end else if (match) begin
      count_nxt = '0;
    end else if (tick) begin
      count_nxt = count_r + 1'b1;
    end
    irq_nxt = match;
  end

  // ***************************************************************
  // Output flip-flop
  // ***************************************************************
  always_comb begin
    ff_nxt = ff_r;
    if (ctrl.pwm) begin
      if (!ctrl.run) begin
        ff_nxt = 1'b0;
      end else if (ovf) begin
        ff_nxt = 1'b1;
      end else if (pwm_match) begin
        ff_nxt = 1'b0;
      end
    end else begin
      if (ff_set) begin
        ff_nxt = 1'b1;
      end else if (ff_clr) begin
        ff_nxt = 1'b0;
      end else if (match && ctrl.inv_en) begin
        ff_nxt = !ff_r;
      end
    end
    pin_nxt = 1'b0;
    if (ctrl.out_en) begin
      pin_nxt = ctrl.pwm ? (ff_nxt ^ ctrl.low_active) : ff_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= '0;
      ff_r <= 1'b0;
      irq_r <= 1'b0;
      pin_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      ff_r <= ff_nxt;
      irq_r <= irq_nxt;
      pin_r <= pin_nxt;
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  property p_run_clear;
    @(posedge aclk) disable iff (!aresetn) !ctrl.run |=> count_r == '0;
  endproperty
  a_run_clear: assert property (p_run_clear) else $error("count not cleared while stopped");

  property p_match_clear;
    @(posedge aclk) disable iff (!aresetn) match |=> count_r == '0 && irq_r;
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("match did not clear and flag");

  property p_count_step;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl.run && tick && !clr && !match) |=> count_r == $past(count_r) + 1'b1;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step on tick");

  property p_irq_cause;
    @(posedge aclk) disable iff (!aresetn)
      irq_r |-> $past(ctrl.run && tick && eq && !ctrl.pwm);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without compare match");

  property p_pwm_ovf;
    @(posedge aclk) disable iff (!aresetn) ovf |=> ff_r;
  endproperty
  a_pwm_ovf: assert property (p_pwm_ovf) else $error("overflow did not activate pwm");

  property p_pwm_match;
    @(posedge aclk) disable iff (!aresetn) (pwm_match && !at_max) |=> !ff_r;
  endproperty
  a_pwm_match: assert property (p_pwm_match) else $error("match did not deactivate pwm");

  property p_pwm_stop;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl.pwm && !ctrl.run && ctrl.out_en) |=> pin_r == $past(ctrl.low_active);
  endproperty
  a_pwm_stop: assert property (p_pwm_stop) else $error("stopped pwm not inactive");

endmodule
`default_nettype wire

/* File: testbench/pin_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// *****************************************
// Event source and timer output monitor
// *****************************************
module pin_partner (
  input wire logic aclk,
  input wire logic [1:0] timer_output_pin,
  output logic [1:0] event_input_pin
);
  initial begin
    event_input_pin = 2'h0;
  end

  // Pulses span two aclk so the one-aclk sampler sees each edge
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      event_input_pin[ch] <= 1'b1;
      repeat (2) @(posedge aclk);
      event_input_pin[ch] <= 1'b0;
      repeat (2) @(posedge aclk);
    end
  endtask

  task automatic hi_time(input int ch, input int n, output int hi);
    hi = 0;
    repeat (n) begin
      @(posedge aclk);
      if (timer_output_pin[ch] === 1'b1) hi++;
    end
  endtask
endmodule
`default_nettype wire

/* File: testbench/eight_bit_cascadable_timer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module eight_bit_cascadable_timer_tb;
  import timer_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [1:0] aux_tick = 2'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, event_pin, out_pin, irq;
  logic [31:0] rdata, d, d2;
  logic [1:0] r;
  logic [31:0] seed = 32'h24;
  logic [7:0] regs[6] = '{OFS_MODE_LO, OFS_MODE_HI, OFS_CMP_LO, OFS_CMP_HI, OFS_CNT_LO, OFS_CASC_CNT};
  int bad_count = 0;
  int check_count = 0;
  int irq0_n = 0;
  int irq1_n = 0;
  int c, g, hi, n0, n1;

  always #4 aclk = ~aclk;

  always @(posedge aclk) begin
    if (irq[0] === 1'b1) irq0_n++;
    if (irq[1] === 1'b1) irq1_n++;
  end

  cascade_timer_top i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .event_input_pin(event_pin), .aux_count_tick(aux_tick),
    .timer_output_pin(out_pin), .compare_match_irq(irq)
  );

  pin_partner i_pin (.aclk(aclk), .timer_output_pin(out_pin), .event_input_pin(event_pin));

  function automatic int rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return int'(seed & 32'h7FFFFFFF);
  endfunction

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  // *****************************************
  // Bus master
  // *****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      rs = bresp;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      v = rdata;
      rs = rresp;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Cycles from one match pulse to the next
  task automatic gap(input int ch, output int n);
    n = 0;
    do @(posedge aclk); while (irq[ch] !== 1'b1);
    do begin
      @(posedge aclk);
      n++;
    end while (irq[ch] !== 1'b1 && n < 2000);
  endtask

  initial begin
    repeat (30000) @(posedge aclk);
    bad_count++;
    end_of_test();
  end

  // *****************************************
  // Main sequence
  // *****************************************
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (regs[i]) begin
      rd(regs[i], d, r);
      chk("reset value", 32'h0, d);
    end
    rd(8'h30, d, r);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
    for (int i = 0; i < 4; i++) begin
      c = (i == 0) ? 0 : (i == 1) ? 255 : rnd() % 256;
      wr(OFS_CMP_HI, 32'(c), r);
      rd(OFS_CMP_HI, d, r);
      chk("compare rw", 32'(c), d);
    end
    wr(OFS_CNT_LO, 32'hA5, r);
    rd(OFS_CNT_LO, d, r);
    chk("count read only", 32'h0, d);
    wr(OFS_MODE_LO, 32'h10, r);
    rd(OFS_MODE_LO, d, r);
    chk("lower cascade bit", 32'h0, d);
    // Interval timer, compare zero then random
    wr(OFS_CLKSEL_LO, 32'(CLK_DIV1), r);
    for (int i = 0; i < 2; i++) begin
      c = (i == 0) ? 0 : rnd() % 30 + 2;
      wr(OFS_MODE_LO, 32'h0, r);
      wr(OFS_CMP_LO, 32'(c), r);
      n1 = irq1_n;
      wr(OFS_MODE_LO, 32'h80, r);
      gap(0, g);
      chk("interval period", 32'(c + 1), 32'(g));
      chk("upper irq idle", 32'(n1), 32'(irq1_n));
    end
    wr(OFS_MODE_LO, 32'h0, r);
    rd(OFS_CNT_LO, d, r);
    chk("stopped count", 32'h0, d);
    // Event counting on the upper channel
    wr(OFS_CLKSEL_HI, 32'(CLK_EV_RISE), r);
    wr(OFS_CMP_HI, 32'hFF, r);
    wr(OFS_MODE_HI, 32'h80, r);
    c = rnd() % 15 + 1;
    i_pin.pulse(1, c);
    repeat (4) @(posedge aclk);
    rd(OFS_CNT_HI, d, r);
    chk("event count", 32'(c), d);
    wr(OFS_MODE_HI, 32'h0, r);
    // Cascaded interval, compare changed only while stopped
    wr(OFS_MODE_HI, 32'h90, r);
    c = 32'h100 + rnd() % 64;
    wr(OFS_CASC_CMP, 32'(c), r);
    rd(OFS_CASC_CMP, d, r);
    chk("cascade compare", 32'(c), d);
    n1 = irq1_n;
    wr(OFS_MODE_LO, 32'h80, r);
    gap(0, g);
    chk("cascade period", 32'(c + 1), 32'(g));
    chk("cascade upper irq", 32'(n1), 32'(irq1_n));
    rd(OFS_CNT_LO, d, r);
    chk("half read resp", 32'(RESP_SLVERR), 32'(r));
    rd(OFS_CASC_CNT, d, r);
    rd(OFS_CASC_CNT, d2, r);
    chk("cascade count range", 32'h1, 32'(d <= 32'(c) && d2 <= 32'(c)));
    wr(OFS_MODE_LO, 32'h0, r);
    rd(OFS_CASC_CNT, d, r);
    chk("cascade clear", 32'h0, d);
    wr(OFS_MODE_HI, 32'h0, r);
    // Pulse width modulation
    c = rnd() % 200 + 16;
    wr(OFS_CMP_LO, 32'(c), r);
    n0 = irq0_n;
    wr(OFS_MODE_LO, 32'hC1, r);
    repeat (300) @(posedge aclk);
    i_pin.hi_time(0, 256, hi);
    chk("pwm high time", 32'(c + 1), 32'(hi));
    chk("pwm no irq", 32'(n0), 32'(irq0_n));
    // Compare rewrite while running, then low-active level
    c = rnd() % 200 + 16;
    wr(OFS_CMP_LO, 32'(c), r);
    wr(OFS_MODE_LO, 32'hC3, r);
    repeat (300) @(posedge aclk);
    i_pin.hi_time(0, 256, hi);
    chk("pwm low active", 32'(255 - c), 32'(hi));
    wr(OFS_MODE_LO, 32'h41, r);
    repeat (2) @(posedge aclk);
    chk("pwm stopped pin", 32'h0, 32'(out_pin[0]));
    // Output flip-flop set and clear, then square wave on a divided clock
    wr(OFS_MODE_LO, 32'h09, r);
    chk("ff set", 32'h1, 32'(out_pin[0]));
    wr(OFS_MODE_LO, 32'h05, r);
    chk("ff clear", 32'h0, 32'(out_pin[0]));
    wr(OFS_CLKSEL_LO, 32'(CLK_DIV4), r);
    c = rnd() % 8 + 1;
    wr(OFS_CMP_LO, 32'(c), r);
    wr(OFS_MODE_LO, 32'h83, r);
    gap(0, g);
    chk("divided period", 32'(4 * (c + 1)), 32'(g));
    i_pin.hi_time(0, 8 * (c + 1), hi);
    chk("square wave high", 32'(4 * (c + 1)), 32'(hi));
    end_of_test();
  end
endmodule
`default_nettype wire
